// ---- hdl/sbcm_pkg.sv ----
// Shared constants and types for the counter compare match block.
package sbcm_pkg;

	localparam int NUM_ENTRIES   = 16;
	localparam int NUM_FLAGS     = 16;
	localparam int NUM_OUTS      = 2;
	localparam int CNT_W         = 32;
	localparam int MS_W          = 10;
	localparam int MS_CNT_W      = 17;
	localparam int ENTRY_CNT_W   = 5;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_PERIOD_NS  = 1000000;
	localparam int MS_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;

	localparam logic [NUM_FLAGS-1:0] FLAGS_RST    = 16'h0000;
	localparam logic [NUM_OUTS-1:0]  EXT_OUT_RST  = 2'h0;
	localparam logic [NUM_OUTS-1:0]  EXT_EN_RST   = 2'h0;
	localparam logic [MS_W-1:0]      MS_RST       = 10'h000;
	localparam logic [MS_CNT_W-1:0]  TICK_CNT_RST = 17'h00000;

	typedef logic [NUM_FLAGS-1:0]                   sbcm_flags_t;
	typedef logic signed [CNT_W-1:0]                sbcm_value_t;
	typedef logic [NUM_ENTRIES-1:0][CNT_W-1:0]      sbcm_limits_t;
	typedef logic [NUM_ENTRIES-1:0][NUM_FLAGS-1:0]  sbcm_patterns_t;
	typedef logic [NUM_OUTS-1:0][MS_W-1:0]          sbcm_times_t;

	typedef enum logic [2:0]
	{
		TM_IDLE  = 3'b001,
		TM_DELAY = 3'b010,
		TM_ON    = 3'b100
	} sbcm_tstate_t;

endpackage : sbcm_pkg

// ---- hdl/sbcm_entry.sv ----
// One comparison entry: target equality and band membership.
`timescale 1ns/1ps
`default_nettype none
module sbcm_entry
	import sbcm_pkg::*;
(
	input  wire logic        active,
	input  wire sbcm_value_t value,
	input  wire sbcm_value_t lower,
	input  wire sbcm_value_t upper,
	output logic             equal,
	output logic             inBand
);

	// Entries are signed so negative targets order correctly.
	always_comb
	begin
		equal  = active && (value == lower);
		inBand = active && (value >= lower) && (value <= upper);
	end

endmodule : sbcm_entry
`default_nettype wire

// ---- hdl/sbcm_out_timer.sv ----
// ON delay and ON hold timing for one external output.
`timescale 1ns/1ps
`default_nettype none
module sbcm_out_timer
	import sbcm_pkg::*;
(
	input  wire logic            mclk,
	input  wire logic            nrst,
	input  wire logic            clkEn,
	input  wire logic            flagIn,
	input  wire logic            timed,
	input  wire logic            msTick,
	input  wire logic [MS_W-1:0] delayMs,
	input  wire logic [MS_W-1:0] holdMs,
	output logic                 timedOut
);

	typedef struct packed
	{
		sbcm_tstate_t    st;
		logic [MS_W-1:0] msCnt;
		logic            out;
	} sbcm_timer_state_t;

	sbcm_timer_state_t s_r;
	sbcm_timer_state_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		case (s_r.st)
			TM_IDLE:
			begin
				if (flagIn && (!timed || delayMs == MS_RST))
				begin
					s_nxt.st    = TM_ON;
					s_nxt.msCnt = MS_RST;
				end
				else if (flagIn)
				begin
					s_nxt.st    = TM_DELAY;
					s_nxt.msCnt = MS_RST;
				end
			end
			TM_DELAY:
			begin
				if (!flagIn || !timed)
					s_nxt.st = TM_IDLE;
				else if (msTick)
				begin
					s_nxt.msCnt = s_r.msCnt + 10'h001;
					if (s_nxt.msCnt >= delayMs)
					begin
						s_nxt.st    = TM_ON;
						s_nxt.msCnt = MS_RST;
					end
				end
			end
			TM_ON:
			begin
				if (timed && msTick && s_r.msCnt < holdMs)
					s_nxt.msCnt = s_r.msCnt + 10'h001;
				if (!flagIn && (!timed || s_r.msCnt >= holdMs))
					s_nxt.st = TM_IDLE;
			end
			default:
			begin
				s_nxt.st    = TM_IDLE;
				s_nxt.msCnt = MS_RST;
			end
		endcase
		s_nxt.out = (s_nxt.st == TM_ON);
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			s_r.st    <= TM_IDLE;
			s_r.msCnt <= MS_RST;
			s_r.out   <= 1'b0;
		end
		else if (clkEn)
			s_r <= s_nxt;
	end

	assign timedOut = s_r.out;

endmodule : sbcm_out_timer
`default_nettype wire

// ---- hdl/sbcm_core.sv ----
// Comparison match logic for one high-speed counter channel.
//
// Functional notes
// - Sixteen comparison entries, 0 to 15, are checked against the count.
// - Sixteen match flags, 0 to F, are presented to the host.
// - One entry may act on several flags, each chosen independently.
// - Target mode sets or clears flags when the count equals a target.
// - Each entry has up-set, up-clear, down-set and down-clear patterns.
// - Up and down matches on one entry may act differently.
// - Band mode drives flags while the count lies within the limits.
// - Each band entry holds an on or off state per affected flag.
// - Band mode acts the same whatever the count direction.
// - Output 0 follows only flag 0; output 1 follows only flag 1.
// - Band mode delays output turn-on by 0 to 1023 ms.
// - Band mode holds an asserted output on for 0 to 1023 ms.
// - Delay and hold combine: delay first, then hold.
// - Target mode passes flags 0 and 1 to outputs without timing.
// - A forced override drives both outputs regardless of flags.
// - After reset both output assignments are disabled.
// - Entries need no particular order to be evaluated correctly.
// - Target or band method is selected per channel.
// - Up patterns apply when incrementing, down patterns when decrementing.
`timescale 1ns/1ps
`default_nettype none
module sbcm_core
	import sbcm_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
	input  wire logic                   mclk,
	input  wire logic                   nrst,
	input  wire logic                   clkEn,
	input  wire sbcm_value_t            countValue,
	input  wire logic                   countUpdate,
	input  wire logic                   countUp,
	input  wire logic                   bandMode,
	input  wire logic [ENTRY_CNT_W-1:0] numEntries,
	input  wire sbcm_limits_t           compareLo,
	input  wire sbcm_limits_t           compareHi,
	input  wire sbcm_patterns_t         upSetPat,
	input  wire sbcm_patterns_t         upClrPat,
	input  wire sbcm_patterns_t         downSetPat,
	input  wire sbcm_patterns_t         downClrPat,
	input  wire sbcm_patterns_t         bandFlagSel,
	input  wire sbcm_patterns_t         bandOnState,
	input  wire logic [NUM_OUTS-1:0]    extOutEnable,
	input  wire sbcm_times_t            onDelayMs,
	input  wire sbcm_times_t            onHoldMs,
	input  wire logic                   forceEnable,
	input  wire logic [NUM_OUTS-1:0]    forceLevel,
	output logic [NUM_FLAGS-1:0]        matchFlag,
	output logic [NUM_OUTS-1:0]         extOut
);

	localparam logic [MS_CNT_W-1:0] TICK_LAST = MS_CNT_W'(MS_CYCLES - 1);

	typedef struct packed
	{
		sbcm_flags_t          flags;
		logic [NUM_OUTS-1:0]  extEn;
		logic [NUM_OUTS-1:0]  ext;
		logic [MS_CNT_W-1:0]  tickCnt;
		logic                 msTick;
	} sbcm_core_state_t;

	sbcm_core_state_t s_r;
	sbcm_core_state_t s_nxt;

	logic [NUM_ENTRIES-1:0] entryEq;
	logic [NUM_ENTRIES-1:0] entryIn;
	logic [NUM_OUTS-1:0]    timedOut;

	// Every entry has its own comparator, so order does not matter.
	for (genvar e = 0; e < NUM_ENTRIES; e++)
	begin : g_entry
		sbcm_entry u_entry
		(
			.active (ENTRY_CNT_W'(e) < numEntries),
			.value  (countValue),
			.lower  (compareLo[e]),
			.upper  (compareHi[e]),
			.equal  (entryEq[e]),
			.inBand (entryIn[e])
		);
	end

	// Flags 0 and 1 feed their own output timer only.
	for (genvar o = 0; o < NUM_OUTS; o++)
	begin : g_out
		sbcm_out_timer u_timer
		(
			.mclk     (mclk),
			.nrst     (nrst),
			.clkEn    (clkEn),
			.flagIn   (s_r.flags[o]),
			.timed    (bandMode),
			.msTick   (s_r.msTick),
			.delayMs  (onDelayMs[o]),
			.holdMs   (onHoldMs[o]),
			.timedOut (timedOut[o])
		);
	end

	always_comb
	begin
		sbcm_flags_t setMask;
		sbcm_flags_t clrMask;
		sbcm_flags_t covered;
		sbcm_flags_t bandOn;
		sbcm_flags_t restOn;
		setMask = '0;
		clrMask = '0;
		covered = '0;
		bandOn  = '0;
		restOn  = '0;
		s_nxt   = s_r;

		// Millisecond tick for the output timers.
		s_nxt.msTick = (s_r.tickCnt == TICK_LAST);
		if (s_nxt.msTick)
			s_nxt.tickCnt = TICK_CNT_RST;
		else
			s_nxt.tickCnt = s_r.tickCnt + 17'h00001;

		for (int e = 0; e < NUM_ENTRIES; e++)
		begin
			if (entryEq[e] && countUp)
			begin
				setMask = setMask | upSetPat[e];
				clrMask = clrMask | upClrPat[e];
			end
			if (entryEq[e] && !countUp)
			begin
				setMask = setMask | downSetPat[e];
				clrMask = clrMask | downClrPat[e];
			end
			if (entryIn[e])
			begin
				covered = covered | bandFlagSel[e];
				bandOn  = bandOn | (bandFlagSel[e] & bandOnState[e]);
			end
			restOn = restOn | (bandFlagSel[e] & ~bandOnState[e]);
		end

		if (bandMode)
			s_nxt.flags = (covered & bandOn) | (~covered & restOn);
		else if (countUpdate)
			s_nxt.flags = (s_r.flags | setMask) & ~clrMask;

		s_nxt.extEn = extOutEnable;
		for (int o = 0; o < NUM_OUTS; o++)
		begin
			if (forceEnable)
				s_nxt.ext[o] = forceLevel[o];
			else
				s_nxt.ext[o] = s_r.extEn[o] & timedOut[o];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			s_r.flags   <= FLAGS_RST;
			s_r.extEn   <= EXT_EN_RST;
			s_r.ext     <= EXT_OUT_RST;
			s_r.tickCnt <= TICK_CNT_RST;
			s_r.msTick  <= 1'b0;
		end
		else if (clkEn)
			s_r <= s_nxt;
	end

	assign matchFlag = s_r.flags;
	assign extOut    = s_r.ext;

endmodule : sbcm_core
`default_nettype wire

// ---- sim/sbcm_asserts.sv ----
// Checker for the counter compare match block.
`timescale 1ns/1ps
`default_nettype none
module sbcm_asserts
	import sbcm_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
	input wire logic                 mclk,
	input wire logic                 nrst,
	input wire logic                 clkEn,
	input wire logic                 countUpdate,
	input wire logic                 bandMode,
	input wire logic [NUM_OUTS-1:0]  extOutEnable,
	input wire sbcm_times_t          onHoldMs,
	input wire logic                 forceEnable,
	input wire logic [NUM_OUTS-1:0]  forceLevel,
	input wire logic [NUM_FLAGS-1:0] matchFlag,
	input wire logic [NUM_OUTS-1:0]  extOut
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_low0;
		(clkEn && !bandMode && !forceEnable && !matchFlag[0])[*3];
	endsequence
	sequence s_high0;
		(clkEn && !bandMode && !forceEnable && extOutEnable[0]
			&& matchFlag[0])[*3];
	endsequence
	a_reset_flags: assert property (disable iff (1'b0)
		!nrst |=> matchFlag == '0) else $error("flags not cleared");
	a_reset_outs: assert property (disable iff (1'b0)
		!nrst |=> extOut == '0) else $error("outputs not cleared");
	a_target_pass: assert property (s_high0 |=> extOut[0])
		else $error("output 0 missed flag 0");
	a_target_idle: assert property (s_low0 |=> !extOut[0])
		else $error("output 0 on without flag 0");
	a_force_level: assert property (clkEn && forceEnable
		|=> extOut == $past(forceLevel)) else $error("force ignored");
	a_idle_hold: assert property (clkEn && !bandMode && !countUpdate
		|=> $stable(matchFlag)) else $error("flags moved with no update");
	a_freeze_all: assert property (!clkEn
		|=> $stable(matchFlag) && $stable(extOut)) else $error("not frozen");
	a_band_hold: assert property (bandMode && !forceEnable
		&& onHoldMs[0] >= 2 && $rose(extOut[0]) |=> extOut[0][*4])
		else $error("hold too short");
endmodule : sbcm_asserts
bind sbcm_core sbcm_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.mclk(mclk),
	.nrst(nrst), .clkEn(clkEn), .countUpdate(countUpdate),
	.bandMode(bandMode), .extOutEnable(extOutEnable), .onHoldMs(onHoldMs),
	.forceEnable(forceEnable), .forceLevel(forceLevel),
	.matchFlag(matchFlag), .extOut(extOut));
`default_nettype wire

// ---- sim/sbcm_host.sv ----
// Host model that reads the match flags as input points.
`timescale 1ns/1ps
`default_nettype none
module sbcm_host
	import sbcm_pkg::*;
(
	input  wire logic        mclk,
	input  wire sbcm_flags_t flagsIn,
	output var sbcm_flags_t  flagsRead
);
	always_ff @(posedge mclk)
	begin
		flagsRead <= flagsIn;
	end
endmodule : sbcm_host
`default_nettype wire

// ---- sim/sbcm_core_tb_top.sv ----
// Testbench for the counter compare match block.
`timescale 1ns/1ps
`default_nettype none
module sbcm_core_tb_top
	import sbcm_pkg::*;
;
	logic           mclk = 1'b0, nrst = 1'b0, clkEn = 1'b1;
	logic           countUpdate = 1'b0, countUp = 1'b1, bandMode = 1'b0;
	logic           forceEnable = 1'b0;
	logic [1:0]     forceLevel = 2'h0, extOutEnable = 2'h3, extOut;
	logic [4:0]     numEntries = 5'h10;
	sbcm_value_t    countValue = '0;
	sbcm_limits_t   compareLo = '0, compareHi = '0;
	sbcm_patterns_t upSetPat = '0, upClrPat = '0, downSetPat = '0;
	sbcm_patterns_t downClrPat = '0, bandFlagSel = '0, bandOnState = '0;
	sbcm_times_t    onDelayMs = '0, onHoldMs = '0;
	sbcm_flags_t    matchFlag, flagsRead;
	int             failures = 0, checks = 0;
	always #5 mclk = ~mclk;
	sbcm_core #(.MS_CYCLES(10)) u_dut (.mclk(mclk), .nrst(nrst),
		.clkEn(clkEn), .countValue(countValue), .countUpdate(countUpdate),
		.countUp(countUp), .bandMode(bandMode), .numEntries(numEntries),
		.compareLo(compareLo), .compareHi(compareHi), .upSetPat(upSetPat),
		.upClrPat(upClrPat), .downSetPat(downSetPat),
		.downClrPat(downClrPat), .bandFlagSel(bandFlagSel),
		.bandOnState(bandOnState), .extOutEnable(extOutEnable),
		.onDelayMs(onDelayMs), .onHoldMs(onHoldMs),
		.forceEnable(forceEnable), .forceLevel(forceLevel),
		.matchFlag(matchFlag), .extOut(extOut));
	sbcm_host u_host (.mclk(mclk), .flagsIn(matchFlag), .flagsRead(flagsRead));
	task automatic chk(input string what, input logic [15:0] exp, got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wt
	task automatic upd(input sbcm_value_t v, input logic up);
		@(posedge mclk);
		countValue <= v;
		countUpdate <= 1'b1;
		countUp <= up;
		@(posedge mclk);
		countUpdate <= 1'b0;
		wt(2);
	endtask : upd
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (2000) @(posedge mclk);
		failures++;
		end_of_test();
	end
	initial
	begin
		compareLo[0] = 32'h5;
		upSetPat[0] = 16'h0003;
		downClrPat[0] = 16'h0001;
		compareLo[3] = 32'h5;
		upClrPat[3] = 16'h0002;
		compareLo[1] = 32'hfffffffd;
		downSetPat[1] = 16'h8000;
		compareLo[15] = 32'h64;
		upSetPat[15] = 16'h4000;
		compareLo[2] = 32'ha;
		compareHi[2] = 32'h14;
		bandFlagSel[2] = 16'h0001;
		bandOnState[2] = 16'h0001;
		onDelayMs[0] = 10'h002;
		onHoldMs[0] = 10'h005;
		wt(4);
		chk("flags", 16'h0000, matchFlag);
		chk("outs", 16'h0000, {14'h0, extOut});
		nrst <= 1'b1;
		$display("test reset done");
		upd(5, 1'b1);
		chk("up5", 16'h0001, flagsRead);
		upd(5, 1'b0);
		chk("down5", 16'h0000, flagsRead);
		upd(-3, 1'b0);
		chk("downm3", 16'h8000, flagsRead);
		upd(-3, 1'b1);
		chk("upm3", 16'h8000, flagsRead);
		numEntries <= 5'h0f;
		upd(100, 1'b1);
		chk("inactive15", 16'h8000, flagsRead);
		numEntries <= 5'h10;
		upd(100, 1'b1);
		chk("up100", 16'hc000, flagsRead);
		clkEn <= 1'b0;
		upd(5, 1'b1);
		clkEn <= 1'b1;
		chk("frozen", 16'hc000, flagsRead);
		upd(5, 1'b1);
		wt(1);
		chk("tout0", 16'h0001, {15'h0, extOut[0]});
		extOutEnable <= 2'h0;
		wt(3);
		chk("tdis0", 16'h0000, {15'h0, extOut[0]});
		upd(5, 1'b0);
		extOutEnable <= 2'h3;
		wt(3);
		chk("tout0off", 16'h0000, {15'h0, extOut[0]});
		chk("clr5", 16'hc000, flagsRead);
		$display("test target done");
		@(posedge mclk);
		bandMode <= 1'b1;
		upd(25, 1'b1);
		chk("outband", 16'h0000, flagsRead);
		upd(15, 1'b0);
		chk("inband", 16'h0001, flagsRead);
		chk("delay", 16'h0000, {15'h0, extOut[0]});
		wt(30);
		chk("delayed", 16'h0001, {15'h0, extOut[0]});
		upd(25, 1'b1);
		chk("held", 16'h0001, {15'h0, extOut[0]});
		wt(70);
		chk("released", 16'h0000, {15'h0, extOut[0]});
		$display("test band done");
		@(posedge mclk);
		forceEnable <= 1'b1;
		forceLevel <= 2'h2;
		wt(2);
		chk("forced", 16'h0002, {14'h0, extOut});
		$display("test force done");
		end_of_test();
	end
endmodule : sbcm_core_tb_top
`default_nettype wire
